// *** scibc_pkg.sv ***
`default_nettype none
package scibc_pkg;
    // ****************************************
    // register map, byte offsets on the target port
    // ****************************************
    localparam logic [7:0] BAUD_HIGH_OFS = 8'h40;
    localparam logic [7:0] BAUD_LOW_OFS = 8'h41;
    localparam logic [7:0] CTRL_ONE_OFS = 8'h42;
    localparam logic [7:0] CTRL_TWO_OFS = 8'h43;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] BAUD_HIGH_RST = 8'h00;
    localparam logic [7:0] BAUD_LOW_RST = 8'h04;
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // ****************************************
    // field positions
    // ****************************************
    localparam int HI_BRK_IE_BIT = 7;
    localparam int HI_EDGE_IE_BIT = 6;
    localparam int DIV_WIDTH = 13;
    localparam int DIV_HI_WIDTH = 5;
    localparam int C1_LOOP_BIT = 7;
    localparam int C1_RECEIVER_SOURCE_SELECT_BIT = 5;
    localparam int C1_NINE_BIT = 4;
    localparam int C1_ILT_BIT = 2;
    localparam int C1_PE_BIT = 1;
    localparam int C1_PT_BIT = 0;
    localparam int C2_TIE_BIT = 7;
    localparam int C2_TX_COMPLETE_IRQ_ENABLE_BIT = 6;
    localparam int C2_RIE_BIT = 5;
    localparam int C2_IDLE_IRQ_ENABLE_BIT = 4;
    localparam int C2_TE_BIT = 3;
    localparam int C2_RE_BIT = 2;
    localparam int C2_RWU_BIT = 1;
    localparam int C2_SBK_BIT = 0;
    // mask of the bits that read back from control one (bits 6 and 3 read zero)
    localparam logic [7:0] CTRL_ONE_MASK = 8'hB7;
    // ****************************************
    // timing and framing counts
    // ****************************************
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] BREAK_BITS_SHORT = 4'hA;
    localparam logic [3:0] BREAK_BITS_LONG = 4'hD;
    localparam logic [3:0] DATA_BITS_EIGHT = 4'h8;
    localparam logic [3:0] DATA_BITS_NINE = 4'h9;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_complete_flag;
        logic rx_buffer_full_flag;
        logic idle_flag;
        logic break_detect_flag;
        logic receive_edge_flag;
    } scibc_flags_t;
    typedef struct packed {
        logic [3:0] data_bits;
        logic [3:0] break_bits;
        logic nine_bit;
        logic idle_type_select;
        logic parity_enable;
        logic parity_type;
        logic receiver_wakeup_control;
        logic transmitter_enable;
        logic receiver_enable;
        logic send_break;
    } scibc_frame_t;
endpackage
`default_nettype wire

// *** scibc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module scibc_top
    import scibc_pkg::*;
#(
    parameter logic [7:0] BAUD_LOW_RESET = BAUD_LOW_RST
) (
    input wire logic i_clk, // bus clock, 10 MHz
    input wire logic i_arst_n, // asynchronous reset, active low
    input wire logic i_reg_wr, // target port write strobe
    input wire logic i_reg_rd, // target port read strobe
    input wire logic [7:0] i_reg_addr, // target port byte offset
    input wire logic [7:0] i_reg_wdata, // target port write data
    output logic [7:0] o_reg_rdata, // read data, one cycle after strobe
    output logic o_reg_rvalid, // read data valid pulse
    input wire scibc_flags_t i_flags, // status flags from the datapath
    input wire logic i_long_break_select, // long break option
    input wire logic i_tx_dir_out, // single-wire direction, 1 = drive
    input wire logic i_tx_busy, // transmitter still shifting
    input wire logic i_tx_serial, // transmitter serial output
    input wire logic [8:0] i_tx_char, // character to transmit
    input wire logic [8:0] i_rx_char, // received character
    input wire logic i_rxd_pin, // receive pin level
    input wire logic i_txd_pin, // transmit pin level as read back
    output scibc_frame_t o_frame, // framing controls to the datapath
    output logic o_sample_tick, // sixteen-times oversample enable
    output logic o_baud_running, // baud generator active
    output logic o_irq, // interrupt request, active high
    output logic o_rx_in, // selected receiver input
    output logic o_txd_pin_o, // transmit pin output value
    output logic o_txd_pin_oe, // transmit pin output enable
    output logic o_rxd_released, // receive pin handed to port i/o
    output logic o_tx_parity, // parity bit for the outgoing char
    output logic o_rx_parity_err // parity error on received char
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_n;
    logic rst_n;

    // two stages so release is clean against the clock
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] baud_high_buf;
    logic [4:0] baud_high_work;
    logic [7:0] baud_low;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [12:0] baud_modulo_value;
    logic baud_armed;
    logic wr_high;
    logic wr_low;
    logic wr_one;
    logic wr_two;

    assign wr_high = i_reg_wr && (i_reg_addr == BAUD_HIGH_OFS);
    assign wr_low = i_reg_wr && (i_reg_addr == BAUD_LOW_OFS);
    assign wr_one = i_reg_wr && (i_reg_addr == CTRL_ONE_OFS);
    assign wr_two = i_reg_wr && (i_reg_addr == CTRL_TWO_OFS);

    // high write only fills the buffer; enables in bits 7:6 act at once
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_high_buf <= BAUD_HIGH_RST;
        end else if (wr_high) begin
            baud_high_buf <= i_reg_wdata & 8'hDF; // bit 5 reads zero
        end
    end

    // working high half moves only on the low write
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_high_work <= BAUD_HIGH_RST[DIV_HI_WIDTH-1:0];
            baud_low <= BAUD_LOW_RESET;
        end else if (wr_low) begin
            baud_high_work <= baud_high_buf[DIV_HI_WIDTH-1:0];
            baud_low <= i_reg_wdata;
        end
    end

    assign baud_modulo_value = {baud_high_work, baud_low};

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one <= CTRL_ONE_RST;
        end else if (wr_one) begin
            ctrl_one <= i_reg_wdata & CTRL_ONE_MASK;
        end
    end

    // control two takes writes at any time
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_two <= CTRL_TWO_RST;
        end else if (wr_two) begin
            ctrl_two <= i_reg_wdata;
        end
    end

    // the nonzero reset divisor must not tick before software wants it
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_armed <= 1'b0;
        end else if (wr_two && (i_reg_wdata[C2_TE_BIT] || i_reg_wdata[C2_RE_BIT])) begin
            baud_armed <= 1'b1;
        end
    end

    // ****************************************
    // register read
    // ****************************************
    logic [7:0] next_rdata;

    always_comb begin
        case (i_reg_addr)
            BAUD_HIGH_OFS: next_rdata = baud_high_buf;
            BAUD_LOW_OFS: next_rdata = baud_low;
            CTRL_ONE_OFS: next_rdata = ctrl_one;
            CTRL_TWO_OFS: next_rdata = ctrl_two;
            default: next_rdata = RDATA_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= RDATA_UNMAPPED;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // ****************************************
    // baud generator
    // ****************************************
    logic [12:0] baud_count;
    logic baud_run;

    assign baud_run = baud_armed && (baud_modulo_value != 13'h0000);

    // modulo counter: one tick every divisor cycles, i.e. sixteen per bit
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_count <= 13'h0000;
            o_sample_tick <= 1'b0;
        end else if (!baud_run) begin
            baud_count <= 13'h0000;
            o_sample_tick <= 1'b0;
        end else if (baud_count >= baud_modulo_value - 13'h0001) begin
            baud_count <= 13'h0000;
            o_sample_tick <= 1'b1;
        end else begin
            baud_count <= baud_count + 13'h0001;
            o_sample_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_baud_running <= 1'b0;
        end else begin
            o_baud_running <= baud_run;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    logic next_irq;

    // a level request; flags are cleared by the datapath, not here
    always_comb begin
        next_irq = 1'b0;
        if (baud_high_buf[HI_BRK_IE_BIT] && i_flags.break_detect_flag) begin
            next_irq = 1'b1;
        end
        if (baud_high_buf[HI_EDGE_IE_BIT] && i_flags.receive_edge_flag) begin
            next_irq = 1'b1;
        end
        if ((ctrl_two[C2_TIE_BIT] && i_flags.tx_buffer_empty_flag) ||
            (ctrl_two[C2_TX_COMPLETE_IRQ_ENABLE_BIT] && i_flags.tx_complete_flag) ||
            (ctrl_two[C2_RIE_BIT] && i_flags.rx_buffer_full_flag) ||
            (ctrl_two[C2_IDLE_IRQ_ENABLE_BIT] && i_flags.idle_flag)) begin
            next_irq = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= next_irq;
        end
    end

    // ****************************************
    // pin routing
    // ****************************************
    logic loop_select;
    logic receiver_source_select;
    logic single_wire;
    logic next_rx_in;
    logic next_txd_oe;

    assign loop_select = ctrl_one[C1_LOOP_BIT];
    assign receiver_source_select = ctrl_one[C1_RECEIVER_SOURCE_SELECT_BIT];
    assign single_wire = loop_select && receiver_source_select;

    always_comb begin
        if (!loop_select) begin
            next_rx_in = i_rxd_pin;
        end else if (receiver_source_select) begin
            next_rx_in = i_txd_pin;
        end else begin
            next_rx_in = i_tx_serial;
        end
    end

    // pin stays driven after enable drops until the shifter is done
    always_comb begin
        next_txd_oe = ctrl_two[C2_TE_BIT] || i_tx_busy;
        if (single_wire && !i_tx_dir_out) begin
            next_txd_oe = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rx_in <= 1'b1;
            o_txd_pin_o <= 1'b1;
            o_txd_pin_oe <= 1'b0;
            o_rxd_released <= 1'b1;
        end else begin
            o_rx_in <= next_rx_in;
            o_txd_pin_o <= i_tx_serial;
            o_txd_pin_oe <= next_txd_oe;
            o_rxd_released <= !ctrl_two[C2_RE_BIT] || loop_select;
        end
    end

    // ****************************************
    // framing controls
    // ****************************************
    scibc_frame_t next_frame;

    always_comb begin
        next_frame.nine_bit = ctrl_one[C1_NINE_BIT];
        next_frame.data_bits = ctrl_one[C1_NINE_BIT] ? DATA_BITS_NINE : DATA_BITS_EIGHT;
        next_frame.idle_type_select = ctrl_one[C1_ILT_BIT];
        next_frame.parity_enable = ctrl_one[C1_PE_BIT];
        next_frame.parity_type = ctrl_one[C1_PT_BIT];
        next_frame.receiver_wakeup_control = ctrl_two[C2_RWU_BIT];
        next_frame.transmitter_enable = ctrl_two[C2_TE_BIT];
        next_frame.receiver_enable = ctrl_two[C2_RE_BIT];
        // break request holds while set; transmitter queues one per frame
        next_frame.send_break = ctrl_two[C2_SBK_BIT] && ctrl_two[C2_TE_BIT];
        next_frame.break_bits = (i_long_break_select ? BREAK_BITS_LONG : BREAK_BITS_SHORT)
            + {3'h0, ctrl_one[C1_NINE_BIT]};
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_frame <= '0;
        end else begin
            o_frame <= next_frame;
        end
    end

    // ****************************************
    // parity
    // ****************************************
    logic [8:0] data_mask;
    logic tx_ones;
    logic rx_ones;

    // MSB of the character (bit 7 or bit 8) is the parity position
    assign data_mask = ctrl_one[C1_NINE_BIT] ? 9'h0FF : 9'h07F;
    assign tx_ones = ^(i_tx_char & data_mask);
    // count includes the received parity bit itself
    assign rx_ones = ^(i_rx_char & {data_mask[7:0], 1'b1});

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_tx_parity <= 1'b0;
            o_rx_parity_err <= 1'b0;
        end else begin
            o_tx_parity <= ctrl_one[C1_PE_BIT] && (tx_ones ^ ctrl_one[C1_PT_BIT]);
            o_rx_parity_err <= ctrl_one[C1_PE_BIT] && (rx_ones != ctrl_one[C1_PT_BIT]);
        end
    end
endmodule // scibc_top
`default_nettype wire

// *** scibc_node.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// remote serial node on the two lines
// ****
module scibc_node (
    input wire logic i_txd_o, // device transmit value
    input wire logic i_txd_oe, // device drives the transmit line
    input wire logic i_drive_en, // node drives its lines
    input wire logic i_drive_val, // node level while driving
    output logic o_txd_line, // resolved transmit line
    output logic o_rxd_line // receive line seen by the device
);
    // both lines carry a pull-up, so a released line reads high, never the last value
    assign o_txd_line = i_txd_oe ? i_txd_o : (i_drive_en ? i_drive_val : 1'b1);
    assign o_rxd_line = i_drive_en ? i_drive_val : 1'b1;
endmodule // scibc_node
`default_nettype wire

// *** scibc_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module scibc_chk
    import scibc_pkg::*;
#(
    parameter logic [7:0] BAUD_LOW_RESET = BAUD_LOW_RST
) (
    input wire logic i_clk, // bus clock
    input wire logic i_arst_n, // reset, active low
    input wire logic i_reg_rd, // read strobe
    input wire logic [7:0] i_reg_addr, // byte offset
    input wire scibc_flags_t i_flags, // status flags
    input wire logic i_tx_dir_out, // single-wire direction
    input wire logic [7:0] o_reg_rdata, // read data
    input wire logic o_reg_rvalid, // read data valid
    input wire scibc_frame_t o_frame, // framing controls
    input wire logic o_sample_tick, // oversample tick
    input wire logic o_baud_running, // generator active
    input wire logic o_irq, // interrupt request
    input wire logic o_rxd_released, // receive pin free
    input wire logic o_txd_pin_oe // transmit pin enable
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // ****
    // register port
    // ****
    sequence s_rd_req; i_reg_rd; endsequence
    sequence s_rd_ans; o_reg_rvalid; endsequence
    property p_rd_answer; s_rd_req |=> s_rd_ans; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_unmapped;
        i_reg_rd && (i_reg_addr < BAUD_HIGH_OFS || i_reg_addr > CTRL_TWO_OFS)
            |=> o_reg_rdata == RDATA_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // ****
    // baud generator, interrupt, pins, frame
    // ****
    property p_tick_running; o_sample_tick |-> o_baud_running; endproperty
    a_tick_running: assert property (p_tick_running) else $error("tick while stopped");
    // with a divisor of one the first tick lands with the running edge, so check the stop side
    property p_tick_stop; $fell(o_baud_running) |-> !o_sample_tick; endproperty
    a_tick_stop: assert property (p_tick_stop) else $error("tick after stop");
    property p_irq_quiet; i_flags == '0 |=> !o_irq; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");
    property p_rx_release; !o_frame.receiver_enable |-> o_rxd_released; endproperty
    a_rx_release: assert property (p_rx_release) else $error("rx pin held");
    property p_tx_drive;
        o_frame.transmitter_enable && $past(i_tx_dir_out) |-> o_txd_pin_oe;
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("tx pin not driven");
    property p_break_gate; o_frame.send_break |-> o_frame.transmitter_enable; endproperty
    a_break_gate: assert property (p_break_gate) else $error("break without tx");
    property p_data_bits;
        o_frame.data_bits != 4'h0
            |-> o_frame.data_bits == (o_frame.nine_bit ? DATA_BITS_NINE : DATA_BITS_EIGHT);
    endproperty
    a_data_bits: assert property (p_data_bits) else $error("data bit count wrong");
endmodule // scibc_chk
bind scibc_top scibc_chk #(.BAUD_LOW_RESET(BAUD_LOW_RESET)) u_scibc_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_flags(i_flags), .i_tx_dir_out(i_tx_dir_out), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_frame(o_frame), .o_sample_tick(o_sample_tick),
    .o_baud_running(o_baud_running), .o_irq(o_irq), .o_rxd_released(o_rxd_released),
    .o_txd_pin_oe(o_txd_pin_oe)
);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import scibc_pkg::*;
    logic i_clk, i_arst_n, i_reg_wr, i_reg_rd, i_long_break_select, i_tx_dir_out;
    logic i_tx_busy, i_tx_serial, i_rxd_pin, i_txd_pin, node_en, node_val;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, hi, c2;
    logic [8:0] i_tx_char, i_rx_char;
    scibc_flags_t i_flags;
    scibc_frame_t o_frame;
    logic o_reg_rvalid, o_sample_tick, o_baud_running, o_irq, o_rx_in, o_txd_pin_o;
    logic o_txd_pin_oe, o_rxd_released, o_tx_parity, o_rx_parity_err;
    int n_mismatch = 0;
    int n_compared = 0;
    scibc_top u_scibc_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_flags(i_flags),
        .i_long_break_select(i_long_break_select), .i_tx_dir_out(i_tx_dir_out),
        .i_tx_busy(i_tx_busy), .i_tx_serial(i_tx_serial), .i_tx_char(i_tx_char),
        .i_rx_char(i_rx_char), .i_rxd_pin(i_rxd_pin), .i_txd_pin(i_txd_pin),
        .o_frame(o_frame), .o_sample_tick(o_sample_tick), .o_baud_running(o_baud_running),
        .o_irq(o_irq), .o_rx_in(o_rx_in), .o_txd_pin_o(o_txd_pin_o),
        .o_txd_pin_oe(o_txd_pin_oe), .o_rxd_released(o_rxd_released),
        .o_tx_parity(o_tx_parity), .o_rx_parity_err(o_rx_parity_err));
    scibc_node u_scibc_node (.i_txd_o(o_txd_pin_o), .i_txd_oe(o_txd_pin_oe),
        .i_drive_en(node_en), .i_drive_val(node_val), .o_txd_line(i_txd_pin),
        .o_rxd_line(i_rxd_pin));
    // ****
    // clock and shared tasks
    // ****
    always #50 i_clk = ~i_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // every request starts after an edge so no signal is assigned twice in a time step
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        settle(1);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        settle(1);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        settle(1);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        settle(1);
        i_reg_rd = 1'b0;
        chk(o_reg_rvalid, 1'b1);
        chk(o_reg_rdata, exp);
    endtask
    // window length a multiple of the divisor, so the count is phase independent
    task automatic ticks(input int n, input int exp);
        int c;
        c = 0;
        repeat (n) begin
            settle(1);
            if (o_sample_tick === 1'b1) c++;
        end
        chk(16'(c), 16'(exp));
    endtask
    task automatic route(input logic [7:0] c1, input logic [4:0] v, input logic [1:0] e);
        wr(CTRL_ONE_OFS, c1);
        {i_tx_dir_out, i_tx_serial, node_en, node_val} = v[3:0];
        settle(3);
        chk(o_rx_in, e[1]);
        chk(o_rxd_released, e[0]);
    endtask
    task automatic irq(input logic [5:0] f, input logic exp);
        wr(BAUD_HIGH_OFS, hi);
        wr(CTRL_TWO_OFS, c2);
        i_flags = f;
        settle(2);
        chk(o_irq, exp);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****
    // watchdog, about seventeen times the expected run
    // ****
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
    // ****
    // main sequence
    // ****
    initial begin
        {i_clk, i_arst_n, i_reg_wr, i_reg_rd, i_long_break_select, i_tx_busy} = 6'h00;
        {i_tx_dir_out, i_tx_serial, node_en, node_val} = 4'h8;
        {i_reg_addr, i_reg_wdata, i_tx_char, i_rx_char, i_flags} = '0;
        settle(2);
        i_arst_n = 1'b1;
        settle(3);
        rd(CTRL_TWO_OFS, 8'h00);
        rd(BAUD_LOW_OFS, BAUD_LOW_RST);
        rd(8'h44, RDATA_UNMAPPED);
        wr(CTRL_TWO_OFS, 8'hF0);
        settle(2);
        chk(o_baud_running, 1'b0);
        wr(CTRL_TWO_OFS, 8'h0C);
        settle(2);
        chk(o_baud_running, 1'b1);
        chk(o_txd_pin_oe, 1'b1);
        settle(8);
        ticks(40, 40 / int'(BAUD_LOW_RST));
        wr(BAUD_HIGH_OFS, 8'h01);
        settle(8);
        ticks(40, 40 / int'(BAUD_LOW_RST));
        rd(BAUD_HIGH_OFS, 8'h01);
        wr(BAUD_LOW_OFS, 8'h00);
        settle(300);
        ticks(512, 2);
        wr(BAUD_HIGH_OFS, 8'h00);
        wr(BAUD_LOW_OFS, 8'h03);
        settle(8);
        ticks(30, 10);
        wr(BAUD_LOW_OFS, 8'h00);
        settle(2);
        chk(o_baud_running, 1'b0);
        ticks(20, 0);
        wr(BAUD_LOW_OFS, 8'h01);
        settle(4);
        ticks(10, 10);
        wr(CTRL_TWO_OFS, 8'hA7);
        rd(CTRL_TWO_OFS, 8'hA7);
        chk(o_frame.receiver_wakeup_control, 1'b1);
        chk(o_frame.receiver_enable, 1'b1);
        chk(o_frame.send_break, 1'b0);
        chk(o_txd_pin_oe, 1'b0);
        wr(CTRL_ONE_OFS, 8'hFF);
        rd(CTRL_ONE_OFS, CTRL_ONE_MASK);
        // break length for both options on eight-bit characters, then the long option on nine
        wr(CTRL_TWO_OFS, 8'h09);
        wr(CTRL_ONE_OFS, 8'h00);
        settle(2);
        chk(o_frame.send_break, 1'b1);
        chk(o_frame.break_bits, BREAK_BITS_SHORT);
        i_long_break_select = 1'b1;
        settle(2);
        chk(o_frame.break_bits, BREAK_BITS_LONG);
        wr(CTRL_ONE_OFS, 8'h10);
        settle(2);
        chk(o_frame.break_bits, BREAK_BITS_LONG + 4'h1);
        chk(o_frame.data_bits, DATA_BITS_NINE);
        // odd parity on nine bits, then even parity on eight
        wr(CTRL_ONE_OFS, 8'h13);
        {i_tx_char, i_rx_char} = {9'h003, 9'h003};
        settle(2);
        chk(o_tx_parity, 1'b1);
        chk(o_rx_parity_err, 1'b1);
        i_rx_char = 9'h103;
        settle(2);
        chk(o_rx_parity_err, 1'b0);
        wr(CTRL_ONE_OFS, 8'h06);
        {i_tx_char, i_rx_char} = {9'h007, 9'h081};
        settle(2);
        chk(o_tx_parity, 1'b1);
        chk(o_rx_parity_err, 1'b0);
        chk(o_frame.idle_type_select, 1'b1);
        chk(o_frame.parity_enable, 1'b1);
        chk(o_frame.parity_type, 1'b0);
        chk(o_frame.data_bits, DATA_BITS_EIGHT);
        // pin routing: {dir, serial, node drives, node level}, {rx input, released}
        wr(CTRL_TWO_OFS, 8'h0C);
        route(8'h20, 5'h0E, 2'h0);
        route(8'h80, 5'h0E, 2'h3);
        route(8'h80, 5'h0B, 2'h1);
        chk(o_txd_pin_o, 1'b0);
        route(8'hA0, 5'h06, 2'h1);
        route(8'hA0, 5'h09, 2'h1);
        wr(CTRL_TWO_OFS, 8'h08);
        route(8'h00, 5'h0E, 2'h1);
        // each enable raises its own flag only
        for (int i = 0; i < 6; i++) begin
            hi = (i < 2) ? 8'(8'h40 << i) : 8'h00;
            c2 = (i < 2) ? 8'h00 : 8'(8'h10 << (i - 2));
            irq(6'(6'h01 << i), 1'b1);
            irq(6'(~(6'h01 << i)), 1'b0);
        end
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
